// File: pkg/tlp_port_pkg.sv
package tlp_port_pkg;
  // transmit buffer accounting
  localparam logic [5:0] TX_BUFFERS_MAX = 6'h20;
  // supported payload; plain default, set to the configured maximum
  localparam logic [11:0] MAX_PAYLOAD_DW = 12'h080;
  localparam logic [11:0] HDR3_DW = 12'h003;
  localparam logic [11:0] HDR4_DW = 12'h004;
  localparam logic [11:0] DIGEST_DW = 12'h001;
  localparam logic [11:0] MAX_PACKET_DW = HDR4_DW + MAX_PAYLOAD_DW + DIGEST_DW;
  localparam logic [11:0] LEN_ZERO_DW = 12'h400;
  localparam logic [11:0] BEAT_DW = 12'h004;
  localparam logic [11:0] DW_SATURATE = 12'hfff;
  // header word 0 sits in the top dword of the first beat
  localparam int DW0_MSB = 127;
  localparam int FMT_DATA_BIT = 30;
  localparam int FMT_4DW_BIT = 29;
  localparam int TD_BIT = 15;
  localparam int LEN_MSB = 9;
  // non-posted fetch credits
  localparam logic [3:0] NP_CREDIT_MAX = 4'hf;
  // bus width selector for the remainder decode
  localparam logic WIDE_BUS = 1'b1;

  typedef enum logic [1:0] {RX_IDLE, RX_POSTED, RX_NONPOSTED} rx_sel_e;
  typedef enum logic [1:0] {TX_IDLE, TX_USER, TX_INTERNAL} tx_own_e;

  typedef struct packed {
    logic [127:0] word;
    logic first;
    logic last;
  } beat_s;

  typedef struct packed {
    beat_s beat;
    logic [1:0] width;
    logic poison;
    logic digest;
    logic drop;
    logic valid;
  } out_s;

  typedef struct packed {
    rx_sel_e rx_sel;
    beat_s [1:0] rx_buf;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] rx_count;
    logic rx_open;
    logic rx_abort;
    logic [3:0] np_credit;
    tx_own_e tx_own;
    out_s out;
    logic [5:0] free;
    logic [11:0] dw_count;
    logic [11:0] dw_expect;
    logic streamed;
    logic poison;
    logic digest;
    logic gap;
    logic dropped;
  } state_s;

  localparam state_s STATE_RESET = '{rx_sel: RX_IDLE, tx_own: TX_IDLE,
                                     free: TX_BUFFERS_MAX, default: '0};
endpackage

// File: rtl/tlp_user_transaction_port.sv
// What this block does
// R1: user raises accept while it can take non-posted
// R2: posted and completions overtake non-posted when blocked
// R3: user drops accept one clock before last
// R4: each fetch pulse releases exactly one non-posted packet; the code does not count a pulse while 15 fetch credits are already held
// R5: first-beat marker on each packet's first word
// R6: abort delivery when the link enters reset
// R7: receive valid only with real packet data
// R8: report free transmit buffers, at most 32
// R9: request internal transmit when own packet ready
// R10: internal packet waits for the user grant
// R11: transmit word moves only on valid and accept
// R12: digest generate with first beat, recompute or append
// R13: drop and flag length or streaming gap violations
// R14: poison on any beat marks the packet
// R15: remainder read only on the accepted last beat
// R16: narrow bus remainder one full, zero upper half
// R17: wide bus remainder selects valid last-beat dwords
// R18: user frames each packet with first and last
// R19: streamed packets arrive on consecutive clocks
// R20: receive word moves only on valid and accept
// R21: source holds word and framing until accepted
`timescale 1ns/10ps
module tlp_user_transaction_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // inbound posted and completion queue
  input wire logic pc_valid,
  input wire tlp_port_pkg::beat_s pc_beat,
  output logic pc_ready,
  // inbound non-posted queue
  input wire logic np_valid,
  input wire tlp_port_pkg::beat_s np_beat,
  output logic np_ready,
  // physical link status
  input wire logic link_reset_entry,
  // user receive
  output logic [127:0] rx_word,
  output logic rx_first_beat,
  output logic rx_last_beat,
  output logic rx_valid,
  output logic rx_abort,
  input wire logic rx_accept,
  input wire logic rx_nonposted_accept,
  input wire logic rx_nonposted_fetch,
  // user transmit
  input wire logic [127:0] tx_word,
  input wire logic tx_valid,
  input wire logic tx_first_beat,
  input wire logic tx_last_beat,
  input wire logic [1:0] tx_last_beat_width,
  input wire logic tx_streamed,
  input wire logic tx_poison,
  input wire logic tx_digest_generate,
  output logic tx_accept,
  output logic tx_dropped,
  output logic [5:0] tx_free_buffers,
  // internally generated packets
  input wire logic int_valid,
  input wire tlp_port_pkg::beat_s int_beat,
  output logic int_ready,
  output logic tx_internal_request,
  input wire logic tx_internal_grant,
  // toward the link
  output tlp_port_pkg::out_s out_pkt,
  input wire logic out_ready,
  input wire logic buf_release
);

  tlp_port_pkg::state_s q;
  tlp_port_pkg::state_s d;
  tlp_port_pkg::beat_s src_beat;
  logic src_valid;
  logic push;
  logic pop;
  logic np_take;
  logic fetch_inc;
  logic stage_free;
  logic int_go;
  logic idle_ok;
  logic tx_fire;
  logic int_fire;
  logic take;
  logic rel;
  logic over;
  logic gap_now;
  logic viol;
  logic [11:0] base;
  logic [11:0] beat_dw;
  logic [11:0] cur_exp;
  logic [12:0] sum_w;
  logic [11:0] sum;

  // dwords carried by the last beat
  function automatic logic [11:0] last_dwords(input logic [1:0] width);
    if (tlp_port_pkg::WIDE_BUS) begin
      last_dwords = {10'h000, width} + 12'h001; // [R17]
    end else begin
      last_dwords = width[0] ? 12'h002 : 12'h001; // [R16]
    end
  endfunction

  // packet length in dwords as the header announces it
  function automatic logic [11:0] expect_dw(input logic [127:0] w);
    logic [31:0] h;
    logic [11:0] len;
    h = w[tlp_port_pkg::DW0_MSB -: 32];
    len = (h[tlp_port_pkg::LEN_MSB:0] == 10'h000) ?
          tlp_port_pkg::LEN_ZERO_DW : {2'h0, h[tlp_port_pkg::LEN_MSB:0]};
    expect_dw = (h[tlp_port_pkg::FMT_4DW_BIT] ? tlp_port_pkg::HDR4_DW :
                 tlp_port_pkg::HDR3_DW) +
                (h[tlp_port_pkg::FMT_DATA_BIT] ? len : 12'h000) +
                {11'h000, h[tlp_port_pkg::TD_BIT]};
  endfunction

  always_comb begin
    d = q;
    src_valid = 1'b0;
    src_beat = '0;
    np_take = 1'b0;
    unique case (q.rx_sel)
      tlp_port_pkg::RX_POSTED: begin
        src_valid = pc_valid;
        src_beat = pc_beat;
      end
      tlp_port_pkg::RX_NONPOSTED: begin
        src_valid = np_valid;
        src_beat = np_beat;
      end
      default: begin
        src_valid = 1'b0;
      end
    endcase
    // link reset pre-empts any push so nothing lands after the flush
    push = src_valid && (q.rx_count != 2'h2) && !link_reset_entry;
    pc_ready = push && (q.rx_sel == tlp_port_pkg::RX_POSTED);
    np_ready = push && (q.rx_sel == tlp_port_pkg::RX_NONPOSTED);
    rx_valid = (q.rx_count != 2'h0); // [R7]
    rx_word = q.rx_buf[q.rd_ptr].word; // [R21]
    rx_first_beat = q.rx_buf[q.rd_ptr].first; // [R5]
    rx_last_beat = q.rx_buf[q.rd_ptr].last;
    rx_abort = q.rx_abort;
    pop = rx_valid && rx_accept; // [R20]

    if (push) begin
      d.rx_buf[q.wr_ptr] = src_beat;
      d.wr_ptr = ~q.wr_ptr;
      if (src_beat.last) begin
        d.rx_sel = tlp_port_pkg::RX_IDLE;
      end
    end
    if (pop) begin
      d.rd_ptr = ~q.rd_ptr;
      d.rx_open = !rx_last_beat;
    end
    d.rx_count = q.rx_count + {1'b0, push} - {1'b0, pop};

    // packet choice is made between packets only
    if (q.rx_sel == tlp_port_pkg::RX_IDLE && !link_reset_entry) begin
      if (np_valid && rx_nonposted_accept) begin
        d.rx_sel = tlp_port_pkg::RX_NONPOSTED;
      end else if (pc_valid) begin
        d.rx_sel = tlp_port_pkg::RX_POSTED; // [R2]
      end else if (np_valid && q.np_credit != 4'h0) begin
        d.rx_sel = tlp_port_pkg::RX_NONPOSTED; // [R4]
        np_take = 1'b1;
      end
    end
    fetch_inc = rx_nonposted_fetch &&
                (q.np_credit != tlp_port_pkg::NP_CREDIT_MAX);
    d.np_credit = q.np_credit + {3'h0, fetch_inc} - {3'h0, np_take}; // [R4]

    d.rx_abort = link_reset_entry && (q.rx_open || q.rx_count != 2'h0 ||
                 q.rx_sel != tlp_port_pkg::RX_IDLE); // [R6]
    if (link_reset_entry) begin
      d.rx_count = 2'h0; // [R6]
      d.wr_ptr = 1'b0;
      d.rd_ptr = 1'b0;
      d.rx_open = 1'b0;
      d.rx_sel = tlp_port_pkg::RX_IDLE;
    end

    // transmit side: one output stage, user or internal owner per packet
    stage_free = !q.out.valid || out_ready;
    int_go = int_valid && tx_internal_grant; // [R10]
    idle_ok = (q.tx_own == tlp_port_pkg::TX_IDLE) && (q.free != 6'h00);
    tx_accept = stage_free && ((q.tx_own == tlp_port_pkg::TX_USER) ||
                               (idle_ok && !int_go));
    int_ready = stage_free && ((q.tx_own == tlp_port_pkg::TX_INTERNAL) ||
                               (idle_ok && int_go));
    tx_internal_request = int_valid; // [R9]
    tx_fire = tx_valid && tx_accept; // [R11]
    int_fire = int_valid && int_ready;

    base = tx_first_beat ? 12'h000 : q.dw_count;
    beat_dw = tx_last_beat ? last_dwords(tx_last_beat_width) :
              tlp_port_pkg::BEAT_DW; // [R15]
    cur_exp = tx_first_beat ? expect_dw(tx_word) : q.dw_expect;
    sum_w = {1'b0, base} + {1'b0, beat_dw};
    sum = sum_w[12] ? tlp_port_pkg::DW_SATURATE : sum_w[11:0];
    over = (cur_exp > tlp_port_pkg::MAX_PACKET_DW) ||
           (sum > tlp_port_pkg::MAX_PACKET_DW);
    // a stall of our own making is never counted as a gap
    gap_now = (q.tx_own == tlp_port_pkg::TX_USER) && q.streamed &&
              tx_accept && !tx_valid;
    // a gap left over from the previous packet must not taint this one
    viol = over || (q.gap && !tx_first_beat) || gap_now ||
           (tx_last_beat && sum != cur_exp);

    d.dropped = 1'b0;
    if (gap_now) begin
      d.gap = 1'b1; // [R13]
    end
    if (tx_fire) begin
      d.out.beat.word = tx_word;
      d.out.beat.first = tx_first_beat;
      d.out.beat.last = tx_last_beat;
      d.out.width = tx_last_beat_width;
      d.out.poison = (tx_first_beat ? 1'b0 : q.poison) || tx_poison; // [R14]
      d.out.digest = tx_first_beat ? tx_digest_generate : q.digest; // [R12]
      d.out.drop = tx_last_beat && viol; // [R13]
      d.out.valid = 1'b1;
      d.poison = d.out.poison;
      d.digest = d.out.digest;
      d.dw_count = sum;
      d.dw_expect = cur_exp;
      if (tx_first_beat) begin
        d.streamed = tx_streamed;
        d.gap = 1'b0;
      end
      d.dropped = tx_last_beat && viol; // [R13]
      d.tx_own = tx_last_beat ? tlp_port_pkg::TX_IDLE :
                 tlp_port_pkg::TX_USER;
    end else if (int_fire) begin
      d.out.beat = int_beat;
      d.out.width = 2'h3;
      d.out.poison = 1'b0;
      d.out.digest = 1'b0;
      d.out.drop = 1'b0;
      d.out.valid = 1'b1;
      d.tx_own = int_beat.last ? tlp_port_pkg::TX_IDLE :
                 tlp_port_pkg::TX_INTERNAL;
    end else if (out_ready) begin
      d.out.valid = 1'b0;
    end

    take = (tx_fire || int_fire) && (q.tx_own == tlp_port_pkg::TX_IDLE);
    rel = buf_release && (take || q.free != tlp_port_pkg::TX_BUFFERS_MAX);
    d.free = q.free - {5'h00, take} + {5'h00, rel}; // [R8]

    out_pkt = q.out;
    tx_dropped = q.dropped;
    tx_free_buffers = q.free; // [R8]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q <= tlp_port_pkg::STATE_RESET;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_rx_push_shows: assert property (push |=> rx_valid) // [R7]
    else $error("pushed beat not shown");
  a_rx_first_next: assert property ( // [R5]
    pop && rx_last_beat && !link_reset_entry
    |=> !rx_valid || rx_first_beat)
    else $error("beat after last is not a first beat");
  a_rx_bypass_np: assert property ( // [R2]
    q.rx_sel == tlp_port_pkg::RX_IDLE && !rx_nonposted_accept &&
    pc_valid && !link_reset_entry
    |=> q.rx_sel == tlp_port_pkg::RX_POSTED)
    else $error("posted packet did not overtake");
  a_np_fetch_one: assert property ( // [R4]
    fetch_inc && !np_take |=> q.np_credit == $past(q.np_credit) + 4'h1)
    else $error("fetch pulse not counted once");
  a_rx_abort_flush: assert property ( // [R6]
    link_reset_entry && rx_valid |=> rx_abort && !rx_valid)
    else $error("link reset did not abort delivery");
  a_rx_hold_word: assert property ( // [R21]
    rx_valid && !rx_accept && !link_reset_entry
    |=> rx_valid && $stable(rx_word) && $stable(rx_last_beat))
    else $error("receive word changed before accept");
  a_free_bound: assert property (tx_free_buffers <= 6'h20) // [R8]
    else $error("free buffer count above maximum");
  a_free_take: assert property ( // [R8]
    tx_fire && q.tx_own == tlp_port_pkg::TX_IDLE && !buf_release
    |=> tx_free_buffers == $past(tx_free_buffers) - 6'h01)
    else $error("buffer not taken at packet start");
  a_int_grant: assert property ( // [R10]
    int_fire && q.tx_own == tlp_port_pkg::TX_IDLE
    |-> tx_internal_grant && tx_internal_request)
    else $error("internal packet sent without grant");
  a_tx_transfer: assert property ( // [R11]
    tx_fire |=> out_pkt.valid && out_pkt.beat.word == $past(tx_word))
    else $error("accepted word not forwarded");
  a_tx_stall: assert property ( // [R11]
    out_pkt.valid && !out_ready |-> !tx_accept)
    else $error("accept raised while stage full");
  a_tx_digest: assert property ( // [R12]
    tx_fire && tx_first_beat
    |=> out_pkt.digest == $past(tx_digest_generate))
    else $error("digest request not carried");
  // back-to-back dropped packets legally pulse on two cycles in a row
  a_tx_drop: assert property ( // [R13]
    tx_fire && tx_last_beat && viol |=> tx_dropped && out_pkt.drop
    ##1 (!tx_dropped || $past(tx_fire && tx_last_beat && viol)))
    else $error("violation not dropped in one pulse");
  a_tx_poison: assert property ( // [R14]
    tx_fire && tx_last_beat && (tx_poison || (q.poison && !tx_first_beat))
    |=> out_pkt.poison)
    else $error("poison lost before last beat");
  a_tx_width: assert property ( // [R15]
    tx_fire && tx_last_beat
    |=> out_pkt.width == $past(tx_last_beat_width))
    else $error("remainder not carried on last beat");
  a_rem_three: assert property ( // [R17]
    tx_fire && tx_first_beat && tx_last_beat &&
    tx_last_beat_width == 2'h2 && cur_exp == 12'h003 |=> !tx_dropped)
    else $error("three dword packet wrongly dropped");

  c_rx_packet: cover property (pop && rx_last_beat);
  c_tx_packet: cover property (tx_fire && tx_last_beat && !viol);
  c_int_packet: cover property (int_fire && int_beat.last);
  c_tx_drop: cover property (tx_dropped);
endmodule

// File: tb/link_sink.sv
`timescale 1ns/10ps
module link_sink (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // packets leaving for the link
  input wire tlp_port_pkg::out_s out_pkt,
  input wire logic slow,
  output logic out_ready,
  output logic buf_release
);
  logic tick_q;
  // slow mode takes a beat every other cycle so the port must hold
  assign out_ready = !slow || tick_q;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tick_q <= 1'b0;
      buf_release <= 1'b0;
    end else begin
      tick_q <= !tick_q;
      // one buffer returns per packet sent, dropped ones included
      buf_release <= out_pkt.valid && out_ready && out_pkt.beat.last;
    end
  end
endmodule

// File: tb/tb_tlp_user_transaction_port.sv
`timescale 1ns/10ps
module tb_tlp_user_transaction_port;
  logic core_clk, rst_b, pc_valid, pc_ready, np_valid, np_ready;
  logic link_reset_entry, rx_first_beat, rx_last_beat, rx_valid;
  logic rx_abort, rx_accept, rx_nonposted_accept, rx_nonposted_fetch;
  logic tx_valid, tx_first_beat, tx_last_beat, tx_streamed, tx_poison;
  logic tx_digest_generate, tx_accept, tx_dropped, int_valid, int_ready;
  logic tx_internal_request, tx_internal_grant, out_ready, buf_release;
  logic slow;
  logic [127:0] rx_word, tx_word;
  logic [1:0] tx_last_beat_width;
  logic [5:0] tx_free_buffers;
  tlp_port_pkg::beat_s pc_beat, np_beat, int_beat;
  tlp_port_pkg::out_s out_pkt, last_out;
  int n_errors, check_count, cycles, n_out, n_np, n_drop, n_abort;
  localparam logic [127:0] HDR_DATA = {32'h60000001, 96'h0};

  tlp_user_transaction_port dut (.core_clk, .rst_b, .pc_valid, .pc_beat,
    .pc_ready, .np_valid, .np_beat, .np_ready, .link_reset_entry, .rx_word,
    .rx_first_beat, .rx_last_beat, .rx_valid, .rx_abort, .rx_accept,
    .rx_nonposted_accept, .rx_nonposted_fetch, .tx_word, .tx_valid,
    .tx_first_beat, .tx_last_beat, .tx_last_beat_width, .tx_streamed,
    .tx_poison, .tx_digest_generate, .tx_accept, .tx_dropped,
    .tx_free_buffers, .int_valid, .int_beat, .int_ready,
    .tx_internal_request, .tx_internal_grant, .out_pkt, .out_ready,
    .buf_release);
  link_sink sink (.core_clk, .rst_b, .out_pkt, .slow, .out_ready,
    .buf_release);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (out_pkt.valid && out_ready) begin
      last_out = out_pkt;
      n_out++;
    end
    if (np_valid && np_ready) n_np++;
    if (tx_dropped === 1'b1) n_drop++;
    if (rx_abort === 1'b1) n_abort++;
    // long enough for every scenario several times over
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(string what, logic [127:0] seen, logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic push_pc(logic [127:0] w, logic f, logic l);
    @(negedge core_clk);
    pc_beat = '{word: w, first: f, last: l};
    pc_valid = 1'b1;
    #1;
    for (int i = 0; i < 50 && pc_ready !== 1'b1; i++) begin
      @(negedge core_clk);
      #1;
    end
    chk("pc_ready", pc_ready, 1'b1);
    @(negedge core_clk);
    pc_valid = 1'b0;
  endtask

  task automatic take_rx(logic [127:0] w, logic f, logic l);
    @(negedge core_clk);
    rx_accept = 1'b1;
    #1;
    for (int i = 0; i < 50 && rx_valid !== 1'b1; i++) begin
      @(negedge core_clk);
      #1;
    end
    chk("rx_valid", rx_valid, 1'b1);
    chk("rx_word", rx_word, w);
    chk("rx_first_beat", rx_first_beat, f);
    chk("rx_last_beat", rx_last_beat, l);
    @(negedge core_clk);
    rx_accept = 1'b0;
  endtask

  task automatic tx_beat(logic [127:0] w, logic f, logic l, logic [1:0] wd,
                         logic p, logic d);
    @(negedge core_clk);
    tx_word = w;
    tx_first_beat = f;
    tx_last_beat = l;
    tx_last_beat_width = wd;
    tx_poison = p;
    tx_digest_generate = d;
    tx_valid = 1'b1;
    #1;
    for (int i = 0; i < 50 && tx_accept !== 1'b1; i++) begin
      @(negedge core_clk);
      #1;
    end
    chk("tx_accept", tx_accept, 1'b1);
  endtask

  task automatic tx_end();
    @(negedge core_clk);
    tx_valid = 1'b0;
  endtask

  task automatic tx_pkt(logic [127:0] w0, logic [1:0] wd, logic two,
                        logic gap);
    tx_beat(w0, 1'b1, !two, wd, 1'b0, 1'b1);
    if (gap) tx_end();
    if (two) tx_beat(128'h0, 1'b0, 1'b1, wd, 1'b1, 1'b0);
    tx_end();
  endtask

  task automatic t_reset();
    chk("free", tx_free_buffers, 6'h20);
    chk("rx_valid", rx_valid, 1'b0);
    chk("request", tx_internal_request, 1'b0);
  endtask

  task automatic t_rx_hold();
    push_pc(128'ha1, 1'b1, 1'b0);
    push_pc(128'hb2, 1'b0, 1'b1);
    cyc(3);
    chk("held valid", rx_valid, 1'b1);
    chk("held word", rx_word, 128'ha1);
    take_rx(128'ha1, 1'b1, 1'b0);
    take_rx(128'hb2, 1'b0, 1'b1);
    chk("drained", rx_valid, 1'b0);
  endtask

  task automatic t_rx_bypass();
    @(negedge core_clk);
    rx_nonposted_accept = 1'b0;
    np_beat = '{word: 128'hc3, first: 1'b1, last: 1'b1};
    np_valid = 1'b1;
    cyc(4);
    chk("np blocked", rx_valid, 1'b0);
    push_pc(128'hd4, 1'b1, 1'b1);
    take_rx(128'hd4, 1'b1, 1'b1);
    rx_nonposted_fetch = 1'b1;
    @(negedge core_clk);
    rx_nonposted_fetch = 1'b0;
    take_rx(128'hc3, 1'b1, 1'b1);
    cyc(8);
    chk("one per fetch", rx_valid, 1'b0);
    rx_nonposted_accept = 1'b1;
    for (int i = 0; i < 50 && n_np < 2; i++) @(negedge core_clk);
    np_valid = 1'b0;
    take_rx(128'hc3, 1'b1, 1'b1);
  endtask

  task automatic t_abort();
    push_pc(128'he5, 1'b1, 1'b0);
    cyc(3);
    link_reset_entry = 1'b1;
    @(negedge core_clk);
    link_reset_entry = 1'b0;
    cyc(3);
    chk("abort", n_abort, 1);
    chk("flushed", rx_valid, 1'b0);
  endtask

  task automatic t_tx_width();
    for (int w = 0; w < 4; w++) begin
      int d0 = n_drop;
      tx_pkt(128'h0, w[1:0], 1'b0, 1'b0);
      chk("free", tx_free_buffers, 6'h1f);
      cyc(3);
      chk("width", last_out.width, w[1:0]);
      chk("drop flag", last_out.drop, w != 2);
      chk("dropped", n_drop - d0, w != 2);
      chk("free back", tx_free_buffers, 6'h20);
    end
  endtask

  task automatic t_tx_multi();
    int d0 = n_drop;
    slow = 1'b1;
    tx_pkt(HDR_DATA, 2'h0, 1'b1, 1'b0);
    cyc(4);
    slow = 1'b0;
    chk("no drop", n_drop - d0, 0);
    chk("poison", last_out.poison, 1'b1);
    chk("digest", last_out.digest, 1'b1);
    chk("last beat", last_out.beat.last, 1'b1);
    for (int s = 0; s < 2; s++) begin
      d0 = n_drop;
      tx_streamed = s[0];
      tx_pkt(HDR_DATA, 2'h0, 1'b1, 1'b1);
      cyc(3);
      chk("gap drop", n_drop - d0, s);
    end
    tx_streamed = 1'b0;
    d0 = n_drop;
    tx_pkt(128'h0, 2'h2, 1'b0, 1'b0);
    cyc(3);
    chk("clean after gap", n_drop - d0, 0);
    chk("poison cleared", last_out.poison, 1'b0);
  endtask

  task automatic t_internal();
    int o0 = n_out;
    @(negedge core_clk);
    tx_internal_grant = 1'b0;
    int_beat = '{word: 128'hf6, first: 1'b1, last: 1'b1};
    int_valid = 1'b1;
    #1;
    chk("request", tx_internal_request, 1'b1);
    cyc(4);
    chk("waits grant", int_ready, 1'b0);
    chk("nothing out", n_out - o0, 0);
    tx_internal_grant = 1'b1;
    #1;
    for (int i = 0; i < 50 && int_ready !== 1'b1; i++) begin
      @(negedge core_clk);
      #1;
    end
    @(negedge core_clk);
    int_valid = 1'b0;
    cyc(3);
    chk("int word", last_out.beat.word, 128'hf6);
    chk("int width", last_out.width, 2'h3);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    {rst_b, pc_valid, np_valid, link_reset_entry, rx_accept} = '0;
    {rx_nonposted_fetch, tx_valid, tx_first_beat, tx_last_beat} = '0;
    {tx_streamed, tx_poison, tx_digest_generate, int_valid, slow} = '0;
    rx_nonposted_accept = 1'b1;
    tx_internal_grant = 1'b1;
    tx_word = '0;
    tx_last_beat_width = '0;
    pc_beat = '0;
    np_beat = '0;
    int_beat = '0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    t_reset();
    t_rx_hold();
    t_rx_bypass();
    t_abort();
    t_tx_width();
    t_tx_multi();
    t_internal();
    finish_test();
  end
endmodule
